// File: hdl/tlppc_top.sv
// Summary of operation
// - Load-point lamp off when marker leaves
// - Forward/dismount at load point moves off marker
// - Lamp off on power-off or column fault
// - Lamp blinks as marker passes while held
// - Load-point press: forward lamp, 42.7 ips seek
// - Seek stops at marker, local to remote
// - Seek aborted by on, off, column fault
// - Press at load point: no motion, go remote
// - Press during interlocked rewind converts it
// - Power-on lamp needs motors, columns, readiness
// - Power-on lamp lights once columns loaded
// - Load-point lamp only with power-on lamp
`timescale 1ns/10ps
`default_nettype none
`include "tlppc_defs.svh"
module tlppc_top
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  // Operator panel switches, high while pressed
  input  wire logic                     sw_forward,
  input  wire logic                     dismount_switch,
  input  wire logic                     sw_load_point,
  input  wire logic                     sw_power_on,
  input  wire logic                     sw_power_off,
  input  wire logic                     sw_rewind,
  // Transport sensors
  input  wire logic                     marker_det,
  input  wire logic                     col_pulled_out,
  input  wire logic                     col_overrun,
  input  wire logic                     cols_loaded,
  input  wire logic                     reel_motors_run,
  input  wire logic                     vac_motor_run,
  // Panel lamps
  output logic                          lp_lamp_r,
  output logic                          on_lamp_r,
  output logic                          local_lamp_r,
  output logic                          remote_lamp_r,
  output logic                          fwd_lamp_r,
  // Transport motion commands
  output logic                          motion_fwd_r,
  output logic                          motion_bwd_r,
  output logic                          seek_slow_r,
  // AXI4-Lite slave
  input  wire logic [`TLP_AXI_AW-1:0]   s_awaddr,
  input  wire logic                     s_awvalid,
  output logic                          s_awready,
  input  wire logic [`TLP_AXI_DW-1:0]   s_wdata,
  input  wire logic [3:0]               s_wstrb,
  input  wire logic                     s_wvalid,
  output logic                          s_wready,
  output logic [1:0]                    s_bresp,
  output logic                          s_bvalid,
  input  wire logic                     s_bready,
  input  wire logic [`TLP_AXI_AW-1:0]   s_araddr,
  input  wire logic                     s_arvalid,
  output logic                          s_arready,
  output logic [`TLP_AXI_DW-1:0]        s_rdata,
  output logic [1:0]                    s_rresp,
  output logic                          s_rvalid,
  input  wire logic                     s_rready
);
  import tlppc_pkg::*;

  logic [`TLP_NSW-1:0]     sw_raw;         // Raw switch bank
  logic [`TLP_NSW-1:0]     sw_sync;        // Synchronised switch levels
  logic [`TLP_NSW-1:0]     sw_prev_r;      // Last cycle's levels, for edges
  logic [`TLP_NSW-1:0]     sw_press;       // One-cycle press pulses
  tlppc_state_t            state_r;        // Motion state
  tlppc_state_t            state_nxt;
  logic                    powered_r;      // Power-on switch latched
  logic                    on_ok;          // Conditions for power-on lamp
  logic                    col_fault;      // Tape out of range in a column
  logic                    abort;          // Stops any panel-started motion
  logic                    go_remote;      // Local to remote handover
  logic                    seek_start;     // Seek begins this cycle
  logic                    rew_start;      // Interlocked rewind begins
  logic                    prog_fwd_r;     // Controller forward command
  logic                    prog_rew_p;     // Program rewind request pulse
  logic                    aw_got_r;       // Write address held
  logic                    w_got_r;        // Write data held
  logic [`TLP_AXI_AW-1:0]  awaddr_r;
  logic [`TLP_AXI_DW-1:0]  wdata_r;
  logic                    wstrb0_r;
  logic [`TLP_AXI_DW-1:0]  status_w;       // Live status word

  // Switch bank in fixed order
  assign sw_raw = {sw_rewind, sw_power_off, sw_power_on,
                   sw_load_point, dismount_switch, sw_forward};

  tlppc_sync u_sync
  (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .raw_in   (sw_raw),
    .sync_out (sw_sync)
  );

  // Edge detector looks only at the second stage
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      sw_prev_r <= '0;
    else
      sw_prev_r <= sw_sync;
  end

  assign sw_press  = sw_sync & ~sw_prev_r;
  assign col_fault = col_pulled_out | col_overrun;

  assign on_ok = powered_r & reel_motors_run & vac_motor_run & cols_loaded & ~col_fault;

  assign abort = sw_press[`TLP_SW_ON] | sw_press[`TLP_SW_OFF] | col_fault;

  // Power latch: on switch arms, off switch disarms
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      powered_r <= 1'b0;
    else if (sw_press[`TLP_SW_OFF])
      powered_r <= 1'b0;
    else if (sw_press[`TLP_SW_ON])
      powered_r <= 1'b1;
  end

  // Motion state decision
  always_comb
  begin
    state_nxt  = state_r;
    go_remote  = 1'b0;
    seek_start = 1'b0;
    rew_start  = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (abort || !on_ok)
          state_nxt = ST_IDLE;
        else if (local_lamp_r && sw_press[`TLP_SW_REW])
        begin
          state_nxt = ST_REW_IL;
          rew_start = 1'b1;
        end
        else if (remote_lamp_r && prog_rew_p)
        begin
          state_nxt = ST_REW_IL;
          rew_start = 1'b1;
        end
        else if (local_lamp_r && sw_press[`TLP_SW_LP])
        begin
          // already at marker, mode change only
          if (marker_det)
            go_remote = 1'b1;
          else
          begin
            state_nxt  = ST_SEEK;
            seek_start = 1'b1;
          end
        end
        // forward or dismount carries tape off marker
        else if (local_lamp_r && (sw_sync[`TLP_SW_FWD] || sw_sync[`TLP_SW_DISM]))
          state_nxt = ST_FWD;
        else if (remote_lamp_r && prog_fwd_r)
          state_nxt = ST_FWD;
      end
      ST_SEEK:
      begin
        if (abort)
          state_nxt = ST_IDLE;
        // halt at marker and go remote
        else if (marker_det)
        begin
          state_nxt = ST_IDLE;
          go_remote = 1'b1;
        end
      end
      ST_REW_IL:
      begin
        if (abort)
          state_nxt = ST_IDLE;
        else if (marker_det)
          state_nxt = ST_IDLE;
        // convert to rewind to load point
        else if (sw_press[`TLP_SW_LP])
          state_nxt = ST_REW_LP;
      end
      ST_REW_LP:
      begin
        if (abort)
          state_nxt = ST_IDLE;
        else if (marker_det)
        begin
          state_nxt = ST_IDLE;
          go_remote = 1'b1;
        end
      end
      ST_FWD:
      begin
        // Held only while the commanding source holds it
        if (abort || !on_ok)
          state_nxt = ST_IDLE;
        else if (local_lamp_r && !(sw_sync[`TLP_SW_FWD] || sw_sync[`TLP_SW_DISM]))
          state_nxt = ST_IDLE;
        else if (remote_lamp_r && !prog_fwd_r)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // one state register, so motions never overlap
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Motion outputs follow the next state so they move with it
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      motion_fwd_r <= 1'b0;
      motion_bwd_r <= 1'b0;
      seek_slow_r  <= 1'b0;
    end
    else
    begin
      motion_fwd_r <= (state_nxt == ST_SEEK) || (state_nxt == ST_FWD);
      motion_bwd_r <= (state_nxt == ST_REW_IL) || (state_nxt == ST_REW_LP);
      // seek runs at the slow speed
      seek_slow_r  <= (state_nxt == ST_SEEK);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      on_lamp_r <= 1'b0;
    else
      on_lamp_r <= on_ok;
  end

  // lamp follows marker, gated by power-on
  // dark on off press or fault
  // Fault drops on_ok, so the column case needs no term of its own
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      lp_lamp_r <= 1'b0;
    else
      lp_lamp_r <= on_ok & marker_det & ~sw_press[`TLP_SW_OFF];
  end

  // Mode lamps; off switch leaves only local lit
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      local_lamp_r  <= 1'b1;
      remote_lamp_r <= 1'b0;
    end
    else if (sw_press[`TLP_SW_OFF] || sw_press[`TLP_SW_ON])
    begin
      local_lamp_r  <= 1'b1;
      remote_lamp_r <= 1'b0;
    end
    else if (go_remote)
    begin
      local_lamp_r  <= 1'b0;
      remote_lamp_r <= 1'b1;
    end
  end

  // Forward lamp: lit by seek or on switch, dark on rewind or off
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fwd_lamp_r <= 1'b0;
    else if (sw_press[`TLP_SW_OFF] || rew_start)
      fwd_lamp_r <= 1'b0;
    else if (seek_start || sw_press[`TLP_SW_ON])
      fwd_lamp_r <= 1'b1;
  end

  // Status word for software
  always_comb
  begin
    status_w                = '0;
    status_w[`TLP_ST_LP]     = lp_lamp_r;
    status_w[`TLP_ST_ON]     = on_lamp_r;
    status_w[`TLP_ST_LOCAL]  = local_lamp_r;
    status_w[`TLP_ST_REMOTE] = remote_lamp_r;
    status_w[`TLP_ST_FWDL]   = fwd_lamp_r;
    status_w[`TLP_ST_MFWD]   = motion_fwd_r;
    status_w[`TLP_ST_MBWD]   = motion_bwd_r;
    status_w[`TLP_ST_SLOW]   = seek_slow_r;
    status_w[`TLP_ST_STATE]  = state_r;
  end

  // Write channels: address and data caught in either order
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end
    else
    begin
      // Ready is registered, so one item per channel per response
      s_awready <= !aw_got_r && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready  <= !w_got_r && !(s_wvalid && s_wready) && !s_bvalid;
      if (s_awvalid && s_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_got_r  <= 1'b1;
        wdata_r  <= s_wdata;
        wstrb0_r <= s_wstrb[0];
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end

  // Write response and control register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_bvalid   <= 1'b0;
      s_bresp    <= `TLP_RESP_OKAY;
      prog_fwd_r <= 1'b0;
      prog_rew_p <= 1'b0;
    end
    else
    begin
      prog_rew_p <= 1'b0;
      if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
      if (aw_got_r && w_got_r)
      begin
        s_bvalid <= 1'b1;
        if (awaddr_r == `TLP_REG_CTRL)
        begin
          s_bresp <= `TLP_RESP_OKAY;
          if (wstrb0_r)
          begin
            prog_fwd_r <= wdata_r[`TLP_CTRL_FWD];
            // Rewind bit is a trigger, never stored
            prog_rew_p <= wdata_r[`TLP_CTRL_REW];
          end
        end
        else if (awaddr_r == `TLP_REG_STATUS)
          s_bresp <= `TLP_RESP_OKAY;
        else
          s_bresp <= `TLP_RESP_SLVERR;
      end
    end
  end

  // Read channel: one read in flight, data registered
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= `TLP_RESP_OKAY;
    end
    else
    begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
      if (s_arvalid && s_arready)
      begin
        s_rvalid <= 1'b1;
        s_rresp  <= `TLP_RESP_OKAY;
        if (s_araddr == `TLP_REG_CTRL)
          s_rdata <= {{(`TLP_AXI_DW-1){1'b0}}, prog_fwd_r};
        else if (s_araddr == `TLP_REG_STATUS)
          s_rdata <= status_w;
        else
        begin
          s_rdata <= '0;
          s_rresp <= `TLP_RESP_SLVERR;
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_lp_needs_on:   assert property (lp_lamp_r |-> on_lamp_r)
    else $error("load-point lamp lit without power-on lamp");
  a_lp_marker:     assert property (on_ok && marker_det && !sw_press[`TLP_SW_OFF]
                     |=> lp_lamp_r)
    else $error("load-point lamp not following marker");
  a_lp_leave:      assert property (!marker_det |=> !lp_lamp_r)
    else $error("load-point lamp stayed on after marker left");
  a_lp_fault:      assert property (col_fault || sw_press[`TLP_SW_OFF] |=> !lp_lamp_r)
    else $error("load-point lamp on during fault or power off");
  a_seek_start:    assert property (seek_start |=> motion_fwd_r && seek_slow_r && fwd_lamp_r)
    else $error("seek did not start forward slow motion");
  a_seek_stop:     assert property (state_r == ST_SEEK && marker_det && !abort
                     |=> !motion_fwd_r && remote_lamp_r && !local_lamp_r)
    else $error("seek did not halt at marker in remote mode");
  a_seek_abort:    assert property (state_r == ST_SEEK && abort
                     |=> state_r == ST_IDLE ##0 !motion_fwd_r)
    else $error("seek not aborted");
  a_lp_at_marker:  assert property (state_r == ST_IDLE && on_ok && !abort && local_lamp_r
                     && marker_det && sw_press[`TLP_SW_LP] && !sw_press[`TLP_SW_REW]
                     |=> !motion_fwd_r && !motion_bwd_r && remote_lamp_r)
    else $error("press at load point moved tape or kept local");
  a_rew_convert:   assert property (state_r == ST_REW_IL && !abort && !marker_det
                     && sw_press[`TLP_SW_LP] |=> state_r == ST_REW_LP && motion_bwd_r)
    else $error("interlocked rewind not converted");
  a_on_lamp:       assert property (on_lamp_r |-> $past(reel_motors_run && vac_motor_run
                     && cols_loaded && powered_r))
    else $error("power-on lamp lit without motors and columns");
  a_on_lights:     assert property (on_ok |=> on_lamp_r)
    else $error("power-on lamp not lit with columns loaded");
  a_motion_excl:   assert property (!(motion_fwd_r && motion_bwd_r))
    else $error("forward and backward motion together");

  c_seek_done:     cover property (state_r == ST_SEEK ##1 state_r == ST_IDLE ##0 remote_lamp_r);
  c_rew_convert:   cover property (state_r == ST_REW_IL ##1 state_r == ST_REW_LP);
  c_lp_blink:      cover property (state_r == ST_FWD && $fell(lp_lamp_r));
  c_seek_abort:    cover property (state_r == ST_SEEK && abort);
endmodule
`default_nettype wire

// File: hdl/tlppc_defs.svh
`ifndef TLPPC_DEFS_SVH
`define TLPPC_DEFS_SVH

// Bus geometry
`define TLP_AXI_AW      4
`define TLP_AXI_DW      32

// Register byte addresses
`define TLP_REG_CTRL    4'h0
`define TLP_REG_STATUS  4'h4

// Control register fields
`define TLP_CTRL_FWD    0
`define TLP_CTRL_REW    1

// Status register fields
`define TLP_ST_LP       0
`define TLP_ST_ON       1
`define TLP_ST_LOCAL    2
`define TLP_ST_REMOTE   3
`define TLP_ST_FWDL     4
`define TLP_ST_MFWD     5
`define TLP_ST_MBWD     6
`define TLP_ST_SLOW     7
`define TLP_ST_STATE    10:8

// Responses
`define TLP_RESP_OKAY   2'h0
`define TLP_RESP_SLVERR 2'h2

// Panel switch bank width and positions
`define TLP_NSW         6
`define TLP_SW_FWD      0
`define TLP_SW_DISM     1
`define TLP_SW_LP       2
`define TLP_SW_ON       3
`define TLP_SW_OFF      4
`define TLP_SW_REW      5

// Seek speed in tenths of an inch per second (42.7 ips)
`define TLP_SEEK_TENTHS_IPS 10'h1ab

`endif

// File: hdl/tlppc_pkg.sv
package tlppc_pkg;
  // Motion states, mutually exclusive by construction
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SEEK   = 3'b001,
    ST_REW_IL = 3'b010,
    ST_REW_LP = 3'b011,
    ST_FWD    = 3'b100
  } tlppc_state_t;
endpackage

// File: hdl/tlppc_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlppc_defs.svh"
// Two-flop synchroniser bank for the panel switches
module tlppc_sync
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Raw and synchronised levels
  input  wire logic [`TLP_NSW-1:0]  raw_in,
  output logic      [`TLP_NSW-1:0]  sync_out
);
  logic [`TLP_NSW-1:0] meta_r;  // First stage, read only by second stage

  genvar gi;
  generate
    for (gi = 0; gi < `TLP_NSW; gi = gi + 1)
    begin : g_bit
      // One bit of the bank
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_r[gi]   <= 1'b0;
          sync_out[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi]   <= raw_in[gi];
          sync_out[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: test/tlppc_transport.sv
`timescale 1ns/10ps
`default_nettype none
// Tape transport stand-in: one position step per clock while driven
module tlppc_transport
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Motion commands from the panel logic
  input  wire logic       move_fwd,
  input  wire logic       move_bwd,
  // Bench repositioning of the tape
  input  wire logic       load_en,
  input  wire logic [7:0] load_pos,
  // Start marker under the detector
  output logic            marker_det
);
  // Marker spans a few steps so a one-cycle stop lag still lands on it
  localparam logic [7:0] MK_LO = 8'h28;
  localparam logic [7:0] MK_HI = 8'h2f;
  logic [7:0] pos_r;       // Tape position

  // Position follows motion; a load wins over motion
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pos_r <= 8'h00;
    else if (load_en)
      pos_r <= load_pos;
    else if (move_fwd)
      pos_r <= pos_r + 8'h01;
    else if (move_bwd)
      pos_r <= pos_r - 8'h01;
  end

  assign marker_det = (pos_r >= MK_LO) && (pos_r <= MK_HI);
endmodule
`default_nettype wire

// File: test/tlppc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlppc_defs.svh"
module tlppc_top_tb;
  // Bench-driven inputs
  logic                  sys_clk, nrst, load_en;
  logic [`TLP_NSW-1:0]   sw;
  logic                  col_pulled_out, col_overrun, cols_loaded;
  logic                  reel_motors_run, vac_motor_run, marker_det;
  logic [7:0]            load_pos;
  // Design outputs
  logic                  lp_lamp_r, on_lamp_r, local_lamp_r, remote_lamp_r, fwd_lamp_r;
  logic                  motion_fwd_r, motion_bwd_r, seek_slow_r;
  // Register bus
  logic [3:0]            awaddr, araddr;
  logic [31:0]           wdata, s_rdata, rd;
  logic                  awvalid, wvalid, bready, arvalid, rready;
  logic                  s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]            s_bresp, s_rresp, rsp;
  // Bookkeeping
  int                    n_fail, cmp_count;
  logic [7:0]            rows [7];

  tlppc_top i_tlppc_top (.sys_clk(sys_clk), .nrst(nrst),
    .sw_forward(sw[`TLP_SW_FWD]), .dismount_switch(sw[`TLP_SW_DISM]),
    .sw_load_point(sw[`TLP_SW_LP]), .sw_power_on(sw[`TLP_SW_ON]),
    .sw_power_off(sw[`TLP_SW_OFF]), .sw_rewind(sw[`TLP_SW_REW]),
    .marker_det(marker_det), .col_pulled_out(col_pulled_out), .col_overrun(col_overrun),
    .cols_loaded(cols_loaded), .reel_motors_run(reel_motors_run),
    .vac_motor_run(vac_motor_run), .lp_lamp_r(lp_lamp_r), .on_lamp_r(on_lamp_r),
    .local_lamp_r(local_lamp_r), .remote_lamp_r(remote_lamp_r), .fwd_lamp_r(fwd_lamp_r),
    .motion_fwd_r(motion_fwd_r), .motion_bwd_r(motion_bwd_r), .seek_slow_r(seek_slow_r),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(s_awready), .s_wdata(wdata),
    .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(rready));

  tlppc_transport i_tlppc_transport (.sys_clk(sys_clk), .nrst(nrst),
    .move_fwd(motion_fwd_r), .move_bwd(motion_bwd_r), .load_en(load_en),
    .load_pos(load_pos), .marker_det(marker_det));

  // 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Switch press long enough to pass the synchroniser and edge detect
  task automatic press(input int i);
    @(posedge sys_clk) sw[i] <= 1'b1;
    cyc(5);
    sw[i] <= 1'b0;
    cyc(4);
  endtask

  // Bounded wait for one of the watched outputs to reach a level
  task automatic wait_for(input int sel, input logic v);
    int n;
    logic cur;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
      case (sel)
        0: cur = lp_lamp_r;
        1: cur = motion_bwd_r;
        2: cur = remote_lamp_r;
        default: cur = on_lamp_r;
      endcase
    end while (cur !== v && n < 300);
    if (cur !== v)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic place(input logic [7:0] p);
    @(posedge sys_clk);
    load_en <= 1'b1;
    load_pos <= p;
    @(posedge sys_clk) load_en <= 1'b0;
    cyc(3);
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (awvalid && s_awready)
        awvalid <= 1'b0;
      if (wvalid && s_wready)
        wvalid <= 1'b0;
      if (s_bvalid)
      begin
        r = s_bresp;
        done = 1'b1;
      end
    end while (!done && n < 100);
    bready <= 1'b0;
    if (!done)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (arvalid && s_arready)
        arvalid <= 1'b0;
      if (s_rvalid)
      begin
        d = s_rdata;
        r = s_rresp;
        done = 1'b1;
      end
    end while (!done && n < 100);
    rready <= 1'b0;
    if (!done)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // Rows: reel, vac, cols, pulled, overrun | check on, on lamp, lp lamp
  initial
  begin
    rows = '{8'he7, 8'h64, 8'ha4, 8'hc4, 8'hf0, 8'he8, 8'he7};
    {nrst, load_en, sw, col_pulled_out, col_overrun} = '0;
    {cols_loaded, reel_motors_run, vac_motor_run} = 3'h7;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, load_pos} = '0;
    n_fail = 0;
    cmp_count = 0;
    cyc(15);
    chk("rst_lamps", {lp_lamp_r, on_lamp_r, local_lamp_r, remote_lamp_r, fwd_lamp_r}, 5'h04);
    chk("rst_motion", {motion_fwd_r, motion_bwd_r, seek_slow_r}, 3'h0);
    @(posedge sys_clk) nrst <= 1'b1;
    press(`TLP_SW_ON);
    wait_for(3, 1'b1);
    place(8'h2a);
    foreach (rows[k])
    begin
      @(posedge sys_clk);
      {reel_motors_run, vac_motor_run, cols_loaded, col_pulled_out, col_overrun} <= rows[k][7:3];
      cyc(5);
      if (rows[k][2])
        chk("on_lamp", on_lamp_r, rows[k][1]);
      chk("lp_lamp", lp_lamp_r, rows[k][0]);
    end
    press(`TLP_SW_ON);
    // Seek from short of the marker
    place(8'h00);
    press(`TLP_SW_LP);
    chk("seek_move", {motion_fwd_r, seek_slow_r, fwd_lamp_r}, 3'h7);
    wait_for(2, 1'b1);
    chk("seek_stop", {motion_fwd_r, local_lamp_r}, 2'h0);
    cyc(2);
    chk("seek_lp", lp_lamp_r, 1'b1);
    // Press at load point: mode change only
    press(`TLP_SW_ON);
    press(`TLP_SW_LP);
    chk("lp_at_mark", {motion_fwd_r, local_lamp_r, remote_lamp_r}, 3'h1);
    // Controller forward moves the marker away
    axi_wr(`TLP_REG_CTRL, 32'h0000_0001, rsp);
    chk("ctrl_wr", rsp, `TLP_RESP_OKAY);
    wait_for(0, 1'b0);
    axi_rd(`TLP_REG_STATUS, rd, rsp);
    chk("st_fwd", {rd[`TLP_ST_MFWD], rd[`TLP_ST_REMOTE], rsp}, 4'hc);
    axi_rd(`TLP_REG_CTRL, rd, rsp);
    chk("ctrl_rd", rd, 32'h0000_0001);
    // Status is read-only: write answered, motion untouched
    axi_wr(`TLP_REG_STATUS, 32'h0000_0000, rsp);
    chk("st_wr", {rsp, motion_fwd_r}, 3'h1);
    axi_wr(`TLP_REG_CTRL, 32'h0000_0000, rsp);
    cyc(3);
    chk("ctrl_stop", motion_fwd_r, 1'b0);
    // Program rewind converted by the load-point switch
    place(8'h64);
    axi_wr(`TLP_REG_CTRL, 32'h0000_0002, rsp);
    press(`TLP_SW_LP);
    axi_rd(`TLP_REG_STATUS, rd, rsp);
    chk("prog_rew", {rd[`TLP_ST_MBWD], rd[`TLP_ST_STATE]}, 4'hb);
    wait_for(1, 1'b0);
    chk("prog_rew_end", {remote_lamp_r, lp_lamp_r}, 2'h3);
    axi_rd(4'h8, rd, rsp);
    chk("unm_rd", rd, 32'h0000_0000);
    chk("unm_rd_rsp", rsp, `TLP_RESP_SLVERR);
    axi_wr(4'hc, 32'h0000_0001, rsp);
    chk("unm_wr", rsp, `TLP_RESP_SLVERR);
    // Seek aborted by the power-on switch
    press(`TLP_SW_ON);
    place(8'h00);
    press(`TLP_SW_LP);
    chk("abort_go", motion_fwd_r, 1'b1);
    press(`TLP_SW_ON);
    chk("abort", {motion_fwd_r, seek_slow_r}, 2'h0);
    // Interlocked rewind converted by the load-point switch
    place(8'h64);
    press(`TLP_SW_REW);
    chk("rew_go", {motion_bwd_r, fwd_lamp_r}, 2'h2);
    press(`TLP_SW_LP);
    wait_for(1, 1'b0);
    chk("rew_lp", remote_lamp_r, 1'b1);
    cyc(2);
    chk("rew_lamp", lp_lamp_r, 1'b1);
    // Marker passes while forward is held: lamp blinks
    press(`TLP_SW_ON);
    place(8'h14);
    @(posedge sys_clk) sw[`TLP_SW_FWD] <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    @(posedge sys_clk) sw[`TLP_SW_FWD] <= 1'b0;
    cyc(6);
    // Dismount held at load point
    place(8'h2a);
    @(posedge sys_clk) sw[`TLP_SW_DISM] <= 1'b1;
    wait_for(0, 1'b0);
    chk("dism_move", motion_fwd_r, 1'b1);
    @(posedge sys_clk) sw[`TLP_SW_DISM] <= 1'b0;
    cyc(6);
    // Power-off at the marker
    place(8'h2a);
    press(`TLP_SW_OFF);
    chk("off_lamps", {lp_lamp_r, on_lamp_r}, 2'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
